// File: hdl/rx_filter_defines.svh
`ifndef RX_FILTER_DEFINES_SVH
`define RX_FILTER_DEFINES_SVH
// Register byte offsets.
`define OFS_RX_CONTROL 12'h000
`define OFS_CSUM_CONTROL 12'h004
`define OFS_FLEX_BUFFER 12'h008
`define OFS_RING_BASE_LOW 12'h010
`define OFS_RING_BASE_HIGH 12'h014
`define OFS_RING_LENGTH 12'h018
`define OFS_RING_HEAD 12'h01c
`define OFS_RING_TAIL 12'h020
`define OFS_MISSED_COUNT 12'h024
`define OFS_CRC_ERROR_COUNT 12'h028
`define EXACT_WINDOW 11:7
`define EXACT_WINDOW_CODE 5'h02
`define EXACT_INDEX 6:3
`define EXACT_HIGH_WORD 2
`define EXACT_VALID 31
`define HASH_WINDOW 11:9
`define HASH_WINDOW_CODE 3'h1
`define HASH_INDEX 8:2
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
// Control fields.
`define STORE_BAD_FRAMES_EN 2
`define PROMISC_UNICAST_EN 3
`define PROMISC_MULTICAST_EN 4
`define LARGE_FRAME_EN 5
`define LONG_FRAME_VARIANT 6
`define HASH_OFFSET 13:12
`define BUFFER_SIZE_SEL 17:16
`define BUFFER_SIZE_EXTEND 25
`define IPV4_OFFLOAD_EN 8
`define L4_OFFLOAD_EN 9
`define IPV6_OFFLOAD_EN 10
`define IPV6_DISABLE 11
`define RING_DESC_COUNT 19:4
`define RING_BASE_KEEP 31:4
// Frame positions and limits, FCS included.
`define POS_TYPE_HIGH 14'd12
`define POS_TYPE_LOW 14'd13
`define POS_L3 14'd14
`define POS_V6_NEXT 14'd20
`define POS_V4_PROTO 14'd23
`define POS_V6_END 14'd54
`define EXT_BASE_BYTES 14'd8
`define CNT_MAX 14'h3fff
`define MIN_FRAME 14'd64
`define MAX_STD_FRAME 14'd1522
`define MAX_JUMBO_FRAME 14'd9014
`define MAX_JUMBO_LONG 14'd9234
// Header codes.
`define SFD_BYTE 8'hd5
`define TYPE_IPV4 16'h0800
`define TYPE_IPV6 16'h86dd
`define NH_UDP 8'h11
`define NH_TCP 8'h06
`define EXT_LEN_MAX 8'h07
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'hedb88320
`define CRC_RESIDUE 32'hdebb20e3
`define IP_SUM_GOOD 16'hffff
`endif

// File: hdl/rx_filter_pkg.sv
package rx_filter_pkg;
  // AXI4-Lite request from the master.
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } axi_req_s;
  // AXI4-Lite answer to the master.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;
  // One receive byte from the PHY side.
  typedef struct packed {
    logic dv;
    logic er;
    logic [7:0] data;
  } rx_byte_s;
  // One descriptor write-back toward host memory.
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
    logic [15:0] index;
    logic [15:0] length;
    logic [7:0] status;
    logic [7:0] descriptor_error_bits;
  } desc_wb_s;
  typedef enum logic [1:0] {WB_IDLE = 2'b00, WB_SEND = 2'b01, WB_WAIT = 2'b10} wb_state_e;
  typedef enum logic [1:0] {L3_NONE = 2'b00, L3_V4 = 2'b01, L3_V6 = 2'b10} l3_e;
endpackage

// File: hdl/rx_filter_ring.sv
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
`include "rx_filter_defines.svh"
// Function
// [RULE1] Exact match against sixteen stored addresses.
// [RULE2] Software leaves exact entry fifteen alone.
// [RULE3] Twelve selected address bits index hash vector.
// [RULE4] Promiscuous classes pass; no inexact flag then.
// [RULE5] No room: drop frame, count it missed.
// [RULE6] Store good frames; bad ones when enabled.
// [RULE7] Frames start only at clean delimiter.
// [RULE8] Large frames up to 9014 or 9234.
// [RULE9] IPv4 version, length, checksum; offload enable.
// [RULE10] Skip only three IPv6 extension kinds.
// [RULE11] Extension size is eight plus eight times length.
// [RULE12] IPv6 passes when enabled and not disabled.
// [RULE13] UDP and TCP recognised; offload enable gates.
// [RULE14] Fixed and flexible receive buffer sizes.
// [RULE15] Write back descriptor, then advance head.
// [RULE16] Head wraps at ring size.
// [RULE17] Head equal tail stalls storing.
// [RULE18] Software writes tail one past last.
// [RULE19] Completed descriptor status never zero.
// [RULE20] Split mode: software steps tail by two.
// [RULE21] Base is two words, low four ignored.
// [RULE22] Ring length is a multiple of 128.
module rx_filter_ring
  import rx_filter_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Register bus.
  input wire axi_req_s axi_req_i,
  output axi_rsp_s axi_rsp_o,
  // Receive byte stream, on clk_i.
  input wire rx_byte_s rx_i,
  // Descriptor write-back toward host memory.
  output desc_wb_s wb_o,
  input wire logic wb_ready_i
);

  ////////////////////////////////////////////////////////////////////////////
  // State: everything the block remembers.
  typedef struct packed {
    logic aw_got;                  // Write address held.
    logic w_got;                   // Write data held.
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    axi_rsp_s rsp;                 // Bus answer flops.
    logic [31:0] rx_control;
    logic [31:0] csum_control;
    logic [3:0] flex_buffer_mult;
    logic [31:0] rx_ring_base_low;
    logic [31:0] rx_ring_base_high;
    logic [19:0] rx_ring_length;
    logic [15:0] rx_ring_head;
    logic [15:0] rx_ring_tail;
    logic [31:0] missed_count;
    logic [31:0] crc_error_count;
    logic [15:0][31:0] exact_low;  // Address bits 31:0.
    logic [15:0][16:0] exact_high; // Valid, then bits 47:32.
    logic [127:0][31:0] hash_vec;  // Multicast acceptance vector.
    logic in_frame;
    logic skip;                    // Errored preamble; wait for idle.
    logic er_seen;
    logic [13:0] cnt;              // Index of the current byte.
    logic [47:0] da;               // First byte lands in 7:0.
    logic [15:0] etype;
    logic [31:0] crc;
    l3_e l3;
    logic [3:0] ihl;
    logic [15:0] ip_sum;
    logic [7:0] hi_byte;
    logic [7:0] nh;                // Current next-header code.
    logic [7:0] nh_pend;
    logic [13:0] hdr_end;          // First byte of the next header.
    logic ext_bad;
    wb_state_e wst;
    desc_wb_s wb;
    logic [13:0] remain;           // Frame bytes not yet described.
    logic [7:0] f_status;
    logic [7:0] f_errors;
  } state_s;

  state_s s;
  state_s next_s;

  // Working values of the combinational process.
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] wr_word;
  logic [7:0] b;
  logic [13:0] c;
  logic [16:0] sum17;
  logic v4_now;
  logic [3:0] ihl_now;
  logic [13:0] v4_end;
  logic ex_hit;
  logic [11:0] hidx;
  logic hash_hit;
  logic mc;
  logic accept;
  logic crc_ok;
  logic len_err;
  logic good;
  logic v4_ok;
  logic v6_ok;
  logic l4_ok;
  logic [13:0] max_len;
  logic [14:0] bufsz;
  logic [13:0] chunk;
  logic [15:0] head_inc;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Reflected CRC-32 over one byte; a good frame leaves the residue.
  function automatic logic [31:0] crc_byte(input logic [31:0] cin, input logic [7:0] d);
    logic [31:0] r;
    r = cin;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? `CRC_POLY : 32'h0000_0000);
    end
    return r;
  endfunction

  // Byte-lane merge of a bus write.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8+:8] = nw[i*8+:8];
      end
    end
    return r;
  endfunction

  // Only hop-by-hop, destination options and routing are skipped.
  function automatic logic is_ext(input logic [7:0] code);
    return (code == 8'h00) || (code == 8'h3c) || (code == 8'h2b); // [RULE10]
  endfunction

  // Receive buffer bytes; a non-zero multiplier wins over the table.
  function automatic logic [14:0] buf_bytes(input logic [1:0] sel, input logic ext, input logic [3:0] mult);
    logic [14:0] r;
    r = 15'd2048;
    if (mult != 4'h0) begin
      r = {1'b0, mult, 10'h000}; // [RULE14]
    end else begin
      unique case ({ext, sel})
        3'b000: r = 15'd2048;
        3'b001: r = 15'd1024;
        3'b010: r = 15'd512;
        3'b011: r = 15'd256;
        3'b100: r = 15'd2048; // Reserved code; treated as the default size.
        3'b101: r = 15'd16384;
        3'b110: r = 15'd8192;
        3'b111: r = 15'd4096; // [RULE14]
      endcase
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    next_s = s;
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    wr_hit = 1'b1;
    wr_word = merge(32'h0000_0000, s.w_data, s.w_strb);
    b = rx_i.data;
    c = s.cnt;
    sum17 = 17'h0_0000;
    ihl_now = (c == `POS_L3) ? b[3:0] : s.ihl;
    v4_now = (c == `POS_L3) ? (s.etype == `TYPE_IPV4 && b[7:4] == 4'h4) : (s.l3 == L3_V4);
    v4_end = `POS_L3 + {8'h00, ihl_now, 2'b00};
    mc = s.da[0];
    crc_ok = (s.crc == `CRC_RESIDUE);
    bufsz = buf_bytes(s.rx_control[`BUFFER_SIZE_SEL], s.rx_control[`BUFFER_SIZE_EXTEND], s.flex_buffer_mult);
    chunk = ({1'b0, s.remain} > bufsz) ? bufsz[13:0] : s.remain;
    head_inc = s.rx_ring_head + 16'h0001;

    // Bus write: address and data are taken in either order.
    if (axi_req_i.awvalid && s.rsp.awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && s.rsp.wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = axi_req_i.wdata;
      next_s.w_strb = axi_req_i.wstrb;
    end
    if (s.rsp.bvalid && axi_req_i.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    // Both halves held and no answer pending: perform the write.
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      if (s.aw_addr[`EXACT_WINDOW] == `EXACT_WINDOW_CODE) begin
        if (s.aw_addr[`EXACT_HIGH_WORD]) begin
          wr_word = merge({s.exact_high[s.aw_addr[`EXACT_INDEX]][16], 15'h0000,
                           s.exact_high[s.aw_addr[`EXACT_INDEX]][15:0]}, s.w_data, s.w_strb);
          next_s.exact_high[s.aw_addr[`EXACT_INDEX]] = {wr_word[`EXACT_VALID], wr_word[15:0]};
        end else begin
          next_s.exact_low[s.aw_addr[`EXACT_INDEX]] =
            merge(s.exact_low[s.aw_addr[`EXACT_INDEX]], s.w_data, s.w_strb);
        end
      end else if (s.aw_addr[`HASH_WINDOW] == `HASH_WINDOW_CODE) begin
        next_s.hash_vec[s.aw_addr[`HASH_INDEX]] = merge(s.hash_vec[s.aw_addr[`HASH_INDEX]], s.w_data, s.w_strb);
      end else begin
        unique case (s.aw_addr)
          `OFS_RX_CONTROL: next_s.rx_control = merge(s.rx_control, s.w_data, s.w_strb);
          `OFS_CSUM_CONTROL: next_s.csum_control = merge(s.csum_control, s.w_data, s.w_strb);
          `OFS_FLEX_BUFFER: next_s.flex_buffer_mult = wr_word[3:0];
          `OFS_RING_BASE_LOW: next_s.rx_ring_base_low = merge(s.rx_ring_base_low, s.w_data, s.w_strb);
          `OFS_RING_BASE_HIGH: next_s.rx_ring_base_high = merge(s.rx_ring_base_high, s.w_data, s.w_strb);
          `OFS_RING_LENGTH: next_s.rx_ring_length = 20'(merge({12'h000, s.rx_ring_length}, s.w_data, s.w_strb));
          `OFS_RING_HEAD: next_s.rx_ring_head = 16'(merge({16'h0000, s.rx_ring_head}, s.w_data, s.w_strb));
          `OFS_RING_TAIL: next_s.rx_ring_tail = 16'(merge({16'h0000, s.rx_ring_tail}, s.w_data, s.w_strb));
          `OFS_MISSED_COUNT, `OFS_CRC_ERROR_COUNT: wr_hit = 1'b1; // Read-only; writes are dropped.
          default: wr_hit = 1'b0;
        endcase
      end
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = wr_hit ? `AXI_OKAY : `AXI_SLVERR;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
    end
    next_s.rsp.awready = !next_s.aw_got;
    next_s.rsp.wready = !next_s.w_got;

    // Bus read: answer one cycle after the address is taken.
    if (axi_req_i.araddr[`EXACT_WINDOW] == `EXACT_WINDOW_CODE) begin
      rd_data = axi_req_i.araddr[`EXACT_HIGH_WORD] ?
                {s.exact_high[axi_req_i.araddr[`EXACT_INDEX]][16], 15'h0000,
                 s.exact_high[axi_req_i.araddr[`EXACT_INDEX]][15:0]} :
                s.exact_low[axi_req_i.araddr[`EXACT_INDEX]];
    end else if (axi_req_i.araddr[`HASH_WINDOW] == `HASH_WINDOW_CODE) begin
      rd_data = s.hash_vec[axi_req_i.araddr[`HASH_INDEX]];
    end else begin
      unique case (axi_req_i.araddr)
        `OFS_RX_CONTROL: rd_data = s.rx_control;
        `OFS_CSUM_CONTROL: rd_data = s.csum_control;
        `OFS_FLEX_BUFFER: rd_data = {28'h000_0000, s.flex_buffer_mult};
        `OFS_RING_BASE_LOW: rd_data = s.rx_ring_base_low;
        `OFS_RING_BASE_HIGH: rd_data = s.rx_ring_base_high;
        `OFS_RING_LENGTH: rd_data = {12'h000, s.rx_ring_length};
        `OFS_RING_HEAD: rd_data = {16'h0000, s.rx_ring_head};
        `OFS_RING_TAIL: rd_data = {16'h0000, s.rx_ring_tail};
        `OFS_MISSED_COUNT: rd_data = s.missed_count;
        `OFS_CRC_ERROR_COUNT: rd_data = s.crc_error_count;
        default: rd_hit = 1'b0;
      endcase
    end
    if (s.rsp.rvalid && axi_req_i.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = rd_data;
      next_s.rsp.rresp = rd_hit ? `AXI_OKAY : `AXI_SLVERR;
    end
    next_s.rsp.arready = !next_s.rsp.rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // Receive side: delimiter hunt, then byte-by-byte parsing.
    if (!rx_i.dv) begin
      next_s.skip = 1'b0;
    end
    if (rx_i.dv && !s.in_frame && !s.skip) begin
      // An errored preamble is not a frame and counts as nothing.
      if (rx_i.er) begin
        next_s.skip = 1'b1; // [RULE7]
      end else if (b == `SFD_BYTE) begin
        next_s.in_frame = 1'b1; // [RULE7]
        next_s.cnt = 14'h0000;
        next_s.crc = `CRC_INIT;
        next_s.er_seen = 1'b0;
        next_s.l3 = L3_NONE;
        next_s.ip_sum = 16'h0000;
        next_s.nh = 8'hff;
        next_s.ext_bad = 1'b0;
      end
    end
    if (rx_i.dv && s.in_frame) begin
      next_s.crc = crc_byte(s.crc, b);
      next_s.er_seen = s.er_seen | rx_i.er;
      // The count saturates so an endless frame still reads oversized.
      if (c != `CNT_MAX) begin
        next_s.cnt = c + 14'd1;
      end
      if (c < 14'd6) begin
        next_s.da = {b, s.da[47:8]};
      end
      if (c == `POS_TYPE_HIGH) begin
        next_s.etype[15:8] = b;
      end
      if (c == `POS_TYPE_LOW) begin
        next_s.etype[7:0] = b;
      end
      if (c == `POS_L3) begin
        next_s.ihl = b[3:0];
        next_s.hdr_end = `POS_V6_END;
        if (v4_now) begin
          next_s.l3 = L3_V4; // [RULE9]
        end else if (s.etype == `TYPE_IPV6 && b[7:4] == 4'h6) begin
          next_s.l3 = L3_V6;
        end
      end
      // Ones-complement sum over the IPv4 header, one word per two bytes.
      if (v4_now && c < v4_end) begin
        if (!c[0]) begin
          next_s.hi_byte = b;
        end else begin
          sum17 = {1'b0, s.ip_sum} + {1'b0, s.hi_byte, b};
          next_s.ip_sum = sum17[15:0] + {15'h0000, sum17[16]}; // [RULE9]
        end
      end
      if (s.l3 == L3_V4 && c == `POS_V4_PROTO) begin
        next_s.nh = b;
      end
      if (s.l3 == L3_V6 && c == `POS_V6_NEXT) begin
        next_s.nh = b;
      end
      // Walk the extension chain; a chain that breaks stays broken.
      if (s.l3 == L3_V6 && c >= `POS_V6_END && is_ext(s.nh) && !s.ext_bad) begin
        if (c == s.hdr_end) begin
          next_s.nh_pend = b;
        end
        if (c == s.hdr_end + 14'd1) begin
          next_s.ext_bad = (b > `EXT_LEN_MAX); // [RULE10]
          next_s.nh = s.nh_pend;
          next_s.hdr_end = s.hdr_end + `EXT_BASE_BYTES + {3'b000, b, 3'b000}; // [RULE11]
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame end: filter, qualify, and hand the frame to the ring.
    ex_hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (s.exact_high[i][16] && {s.exact_high[i][15:0], s.exact_low[i]} == s.da) begin
        ex_hit = 1'b1; // [RULE1]
      end
    end
    unique case (s.rx_control[`HASH_OFFSET])
      2'b00: hidx = s.da[47:36];
      2'b01: hidx = s.da[46:35];
      2'b10: hidx = s.da[45:34];
      2'b11: hidx = s.da[43:32]; // [RULE3]
    endcase
    hash_hit = mc && s.hash_vec[hidx[11:5]][hidx[4:0]]; // [RULE3]
    accept = ex_hit || hash_hit ||
             (mc ? s.rx_control[`PROMISC_MULTICAST_EN] : s.rx_control[`PROMISC_UNICAST_EN]); // [RULE4]
    max_len = !s.rx_control[`LARGE_FRAME_EN] ? `MAX_STD_FRAME :
              s.rx_control[`LONG_FRAME_VARIANT] ? `MAX_JUMBO_LONG : `MAX_JUMBO_FRAME; // [RULE8]
    len_err = (s.cnt < `MIN_FRAME) || (s.cnt > max_len);
    good = crc_ok && !s.er_seen && !len_err; // [RULE6]
    v4_ok = (s.l3 == L3_V4) && (s.ihl >= 4'h5) && s.csum_control[`IPV4_OFFLOAD_EN]; // [RULE9]
    v6_ok = (s.l3 == L3_V6) && !s.ext_bad && !is_ext(s.nh) && s.csum_control[`IPV6_OFFLOAD_EN] &&
            !s.csum_control[`IPV6_DISABLE]; // [RULE12]
    l4_ok = ((v4_ok && s.ip_sum == `IP_SUM_GOOD) || v6_ok) && s.csum_control[`L4_OFFLOAD_EN] &&
            (s.nh == `NH_UDP || s.nh == `NH_TCP); // [RULE13]
    if (s.in_frame && !rx_i.dv) begin
      next_s.in_frame = 1'b0;
      if (!crc_ok) begin
        next_s.crc_error_count = s.crc_error_count + 32'h0000_0001;
      end
      if (accept && (good || s.rx_control[`STORE_BAD_FRAMES_EN])) begin // [RULE6]
        // Only one frame is held; a frame finding it busy has no room.
        if (s.wst != WB_IDLE) begin
          next_s.missed_count = s.missed_count + 32'h0000_0001; // [RULE5]
        end else begin
          next_s.wst = WB_SEND;
          next_s.remain = s.cnt;
          next_s.f_status = 8'h01; // [RULE19]
          next_s.f_status[7] = hash_hit && !ex_hit && !s.rx_control[`PROMISC_MULTICAST_EN] &&
                               !s.rx_control[`PROMISC_UNICAST_EN]; // [RULE4]
          next_s.f_status[6] = v4_ok;
          next_s.f_status[5] = l4_ok;
          next_s.f_status[4] = l4_ok && s.nh == `NH_UDP;
          next_s.f_errors = 8'h00;
          next_s.f_errors[0] = !crc_ok;
          next_s.f_errors[1] = len_err;
          next_s.f_errors[6] = v4_ok && s.ip_sum != `IP_SUM_GOOD;
          next_s.f_errors[7] = s.er_seen;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor write-back, one buffer's worth at a time.
    unique case (s.wst)
      WB_IDLE: begin
        next_s.wb.valid = 1'b0;
      end
      WB_SEND: begin
        // An empty ring holds the frame until software moves the tail.
        if (s.rx_ring_head != s.rx_ring_tail) begin // [RULE17]
          next_s.wb.valid = 1'b1;
          next_s.wb.addr = {s.rx_ring_base_high, s.rx_ring_base_low[`RING_BASE_KEEP], 4'h0} +
                           {44'h000_0000_0000, s.rx_ring_head, 4'h0}; // [RULE21]
          next_s.wb.index = s.rx_ring_head;
          next_s.wb.length = {2'b00, chunk};
          next_s.wb.status = s.f_status | {6'h00, (s.remain == chunk), 1'b1}; // [RULE19]
          next_s.wb.descriptor_error_bits = s.f_errors;
          next_s.wst = WB_WAIT;
        end
      end
      WB_WAIT: begin
        // The head moves only once the write-back has been taken.
        if (wb_ready_i) begin
          next_s.wb.valid = 1'b0;
          next_s.rx_ring_head = (head_inc == s.rx_ring_length[`RING_DESC_COUNT]) ? 16'h0000 : // [RULE16] [RULE22]
                                head_inc; // [RULE15]
          next_s.remain = s.remain - chunk;
          next_s.wst = (s.remain == chunk) ? WB_IDLE : WB_SEND;
        end
      end
      default: begin
        next_s.wst = WB_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset clears everything, including the filter tables.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign axi_rsp_o = s.rsp;
  assign wb_o = s.wb;

endmodule // rx_filter_ring

// File: verif/rx_host_model.sv
`timescale 1ns/1ns
// Host memory side: takes each write-back after a set stall.
module rx_host_model
  import rx_filter_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Write-back channel.
  input wire desc_wb_s wb_i,
  input wire logic [3:0] stall_i,
  output logic ready_o,
  // Record of what was taken.
  output logic [7:0] taken_o,
  output desc_wb_s last_o
);
  logic [3:0] cnt; // Cycles the offer has waited.
  // A slow host proves that the offer is held, not dropped.
  always @(posedge clk_i) begin
    if (reset_i) begin
      ready_o <= 1'b0;
      cnt <= 4'h0;
      taken_o <= 8'h00;
      last_o <= '0;
    end else if (wb_i.valid && ready_o) begin
      ready_o <= 1'b0;
      cnt <= 4'h0;
      taken_o <= taken_o + 8'h01;
      last_o <= wb_i;
    end else if (wb_i.valid) begin
      cnt <= cnt + 4'h1;
      ready_o <= (cnt >= stall_i);
    end
  end
endmodule // rx_host_model

// File: verif/rx_filter_ring_chk.sv
`timescale 1ns/1ns
// Port checker for the receive ring block.
module rx_filter_ring_chk
  import rx_filter_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire axi_req_s axi_req_i,
  input wire axi_rsp_s axi_rsp_o,
  input wire rx_byte_s rx_i,
  input wire desc_wb_s wb_o,
  input wire logic wb_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  sequence wb_wait_s; wb_o.valid && !wb_ready_i; endsequence
  sequence wb_take_s; wb_o.valid && wb_ready_i; endsequence
  a_wb_hold: assert property (wb_wait_s |=> wb_o.valid && $stable(wb_o))
    else $error("write-back changed before taken");
  a_wb_drop: assert property (wb_take_s |=> !wb_o.valid)
    else $error("write-back offered again at once");
  a_status_set: assert property (wb_o.valid |-> wb_o.status[0])
    else $error("status byte zero");
  a_addr_align: assert property (wb_o.valid |-> wb_o.addr[3:0] == 4'h0)
    else $error("descriptor address unaligned");
  a_len_limit: assert property (wb_o.valid |-> wb_o.length != 16'h0 && wb_o.length <= 16'h4000)
    else $error("length outside buffer size");
  a_r_answer: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
    else $error("read answer late");
  a_r_hold: assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
    else $error("read data dropped");
  a_b_answer: assert property (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready
    |=> ##1 axi_rsp_o.bvalid)
    else $error("write answer late");
endmodule // rx_filter_ring_chk
bind rx_filter_ring rx_filter_ring_chk chk (.clk_i(clk_i), .reset_i(reset_i), .axi_req_i(axi_req_i),
  .axi_rsp_o(axi_rsp_o), .rx_i(rx_i), .wb_o(wb_o), .wb_ready_i(wb_ready_i));

// File: verif/tb.sv
`timescale 1ns/1ns
module tb;
  import rx_filter_pkg::*;
  logic clk_i, reset_i, rdy;
  axi_req_s req;
  axi_rsp_s rsp;
  rx_byte_s rx_i;
  desc_wb_s wb, last;
  logic [7:0] taken;
  logic [31:0] d;
  logic [1:0] r;
  int error_cnt, samples_checked, cyc;
  rx_filter_ring uut (.clk_i(clk_i), .reset_i(reset_i), .axi_req_i(req), .axi_rsp_o(rsp), .rx_i(rx_i),
    .wb_o(wb), .wb_ready_i(rdy));
  rx_host_model host (.clk_i(clk_i), .reset_i(reset_i), .wb_i(wb), .stall_i(4'h3), .ready_o(rdy),
    .taken_o(taken), .last_o(last));
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Compare and count.
  task chk(input [127:0] got, input [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Handshakes are judged at the falling edge, where they equal the next rising one.
  task wr(input [11:0] a, input [31:0] v);
    logic ta, tw, tr;
    @(posedge clk_i);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = rsp.awready & req.awvalid;
      tw = rsp.wready & req.wvalid;
      tr = rsp.bvalid & req.bready;
      r = rsp.bresp;
      @(posedge clk_i);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tr) req.bready <= 1'b0;
    end while (!tr);
  endtask
  // Ready is raised late on purpose so the data must stand.
  task rd(input [11:0] a);
    @(posedge clk_i);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(negedge clk_i); while (!rsp.arready);
    @(posedge clk_i) req.arvalid <= 1'b0;
    do @(negedge clk_i); while (!rsp.rvalid);
    @(posedge clk_i) req.rready <= 1'b1;
    @(negedge clk_i);
    d = rsp.rdata;
    r = rsp.rresp;
    @(posedge clk_i) req.rready <= 1'b0;
  endtask
  // Sends preamble, delimiter, 60 bytes and the check sequence; bad[0] spoils it, bad[1] errors the preamble.
  task frame(input [47:0] da, input [1:0] bad);
    logic [7:0] b[64];
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 60; i++) begin
      b[i] = (i < 6) ? da[8*i+:8] : 8'(i);
      c ^= {24'h0, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    c = ~c ^ {31'h0, bad[0]};
    for (int i = 0; i < 4; i++) b[60+i] = c[8*i+:8];
    for (int i = 0; i < 72; i++) begin
      @(posedge clk_i);
      rx_i <= '{1'b1, bad[1] && i == 0, (i < 7) ? 8'h55 : (i == 7) ? 8'hd5 : b[i-8]};
    end
    @(posedge clk_i) rx_i <= '0;
  endtask
  // Waits a bounded time for the host to hold n write-backs.
  task wb_wait(input [7:0] n);
    repeat (60) if (taken !== n) @(posedge clk_i);
    chk(taken, n);
  endtask
  task give_verdict;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    req = '0;
    rx_i = '0;
    reset_i = 1'b1;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(12'h010);
    chk({r, d}, 34'h0);
    rd(12'h0fc);
    chk({r, d}, {2'b10, 32'h0});
    wr(12'h0fc, 32'h1);
    chk(r, 2'b10);
    wr(12'h100, 32'h5e005302);
    wr(12'h104, 32'h80000000);
    wr(12'h010, 32'h1234567f);
    wr(12'h014, 32'h1);
    wr(12'h018, 32'h80);
    wr(12'h020, 32'h2);
    frame(48'h5e005302, 1'b0);
    wb_wait(8'h1);
    chk({last.addr, last.index, last.length, last.status, last.descriptor_error_bits},
      {64'h112345670, 16'h0, 16'h40, 8'h03, 8'h00});
    frame(48'h5e005304, 1'b0);
    frame(48'h5e005302, 1'b1);
    frame(48'h5e005302, 2'b11);
    repeat (30) @(posedge clk_i);
    chk(taken, 8'h1);
    rd(12'h028);
    chk(d, 32'h1);
    wr(12'h000, 32'h8);
    frame(48'h5e005304, 1'b0);
    wb_wait(8'h2);
    chk({last.addr, last.status[7]}, {64'h112345680, 1'b0});
    frame(48'h5e005302, 1'b0);
    frame(48'h5e005302, 1'b0);
    repeat (30) @(posedge clk_i);
    chk(taken, 8'h2);
    wr(12'h020, 32'h3);
    wb_wait(8'h3);
    chk(last.addr, 64'h112345690);
    rd(12'h01c);
    chk(d, 32'h3);
    rd(12'h024);
    chk(d, 32'h1);
    wr(12'h200, 32'h1);
    wr(12'h020, 32'h4);
    frame(48'h1, 1'b0);
    wb_wait(8'h4);
    chk({last.addr, last.status}, {64'h1123456a0, 8'h03});
    wr(12'h000, 32'h0);
    wr(12'h020, 32'h5);
    frame(48'h1, 1'b0);
    wb_wait(8'h5);
    chk(last.status, 8'h83);
    give_verdict();
  end
endmodule // tb
